// ==== verilog/urw_top.sv ====
// Serial receiver wakeup, status flags, 9-bit data, stop freeze and loop routing, APB slave.
// Assumes pins synchronous to pclk and an APB master that waits for pready.
//
// Summary of operation
// - Sleep blocks every receiver flag but edge; idle may still set if idle-in-sleep set.
// - Idle-line wakeup clears sleep after 10, 11 or 12 idle bit times.
// - Sleeping without idle-in-sleep: waking idle does not set idle flag.
// - With idle-in-sleep set, an armed idle detection sets idle flag in sleep too; interrupt if enabled.
// - Idle count starts after start bit, or after stop bit when selected.
// - Address-mark wakeup clears sleep on msb one; two ones with two stops.
// - Address character wakes before its last stop bit and is still received.
// - Three interrupt requests: transmit, receive, error; ten maskable sources.
// - Transmit empty flag set when buffer free; interrupt while set if enabled.
// - Transmit complete set when line idle and nothing queued; interrupt if enabled.
// - Receive full clears by status read while set, then data read.
// - Idle clears the same way; rearms only after a new receive full.
// - Noise, framing, parity errors set with receive full, never on overrun.
// - New character while receive full sets overrun; character and errors dropped.
// - Active receive edge sets edge flag while receiver enabled; write one clears.
// - Ninth transmit bit copied into shifter with data; ninth receive bit held.
// - Stop3 freezes all state except break flag and sleep bit, which a pending strobe still sets or clears; operation resumes on exit.
// - Loop mode feeds transmitter output to receiver; receive pin released.
// - Single-wire mode links receiver to transmit pin; receive pin released.
// - Single-wire direction picks pin input or transmitter drive without loopback.
// - Sixteen samples per bit; bit level is majority of three mid samples.
// - No character transfers to the buffer while framing error stays set.
`timescale 1ns/1ps

module urw_top
  import urw_pkg::*;
#(
  parameter int BAUD_W = 13
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  input wire logic rxd_in,
  input wire logic txd_in,
  output logic txd_out,
  output logic txd_oe,
  output logic rxd_pin_used,
  // Power
  input wire logic stop3_mode,
  // Interrupt requests
  output logic irq_tx,
  output logic irq_rx,
  output logic irq_err
);

  `include "urw_defines.svh"

  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  function automatic logic [3:0] char_bits(input logic nine, input logic two_stop);
    char_bits = `URW_CHAR_BASE + {3'h0, nine} + {3'h0, two_stop};
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `URW_OFF_CTRL1) || (a == `URW_OFF_CTRL2) || (a == `URW_OFF_STAT1) ||
                (a == `URW_OFF_STAT2) || (a == `URW_OFF_CTRL3) || (a == `URW_OFF_DATA) ||
                (a == `URW_OFF_BAUD);
  endfunction

  logic [7:0] ctrl1_q, ctrl2_q, s2ctl_q, ctrl3_q;
  logic [BAUD_W-1:0] baud_q, bcnt_q;
  logic [31:0] rdmux;
  logic [5:0] s1_seen_q;
  logic run, acc, wr, rd, setup, tick16;
  logic receiver_sleep_q, rx_buffer_full_q, idle_q, overrun_q, noise_flag_q;
  logic framing_error_flag_q, parity_error_flag_q, rx_edge_flag_q, line_break_detect_flag_q;
  logic rx_ninth_bit_q, idle_armed_q, rx_prev_q;
  logic [7:0] rx_data_q;
  urw_rx_state_t rx_state_q;
  logic [3:0] rt_q, bit_idx_q, idle_cnt_q, nbits;
  logic [2:0] hist_q, smp_q;
  logic [8:0] shift_q;
  logic noise_acc_q, stop_ferr_q, stop2_q, am_pend_q, am_wake_q, idle_done_q;
  logic xfer_q, x_noise_q, x_ferr_q, x_perr_q, x_brk_q, x_ninth_q;
  logic [7:0] x_data_q;
  logic rx_src, bit_end, maj, noisy, count_ok, idle_hit, idle_set, blocked, rx_edge;
  logic [8:0] frame_bits;
  logic [7:0] tx_buf_q;
  logic [10:0] tx_sh_q;
  logic [3:0] tx_bt_q, tx_cnt_q;
  logic tx_full_q, tx_busy_q, tx_line_q, tx_ninth_q, tx_bit_tick;

  wire loopback_enable = ctrl1_q[`URW_C1_LOOP];
  wire receiver_source_select = ctrl1_q[`URW_C1_RX_SRC];
  wire nine_bit = ctrl1_q[`URW_C1_NINE];
  wire wake_addr_mark = ctrl1_q[`URW_C1_WAKE];
  wire idle_count_after_stop = ctrl1_q[`URW_C1_IDLE_AFTER_STOP];
  wire two_stop_bits = ctrl1_q[`URW_C1_TWO_STOP];
  wire rx_enable = ctrl2_q[`URW_C2_RE];
  wire tx_enable = ctrl2_q[`URW_C2_TE];
  wire idle_flag_in_sleep = s2ctl_q[`URW_S2_IDLE_SLEEP];
  wire tx_ninth_bit = ctrl3_q[`URW_C3_TX9];
  wire single_wire_direction = ctrl3_q[`URW_C3_SW_DIR];
  wire tx_buffer_empty = ~tx_full_q;
  wire tx_complete = ~tx_full_q & ~tx_busy_q;

  // Stop3: every enable below is gated but the break-flag set and the am_wake_q sleep clear, so other state holds
  assign run = ~stop3_mode;
  assign pready = run;
  assign setup = psel & ~penable;
  assign acc = psel & penable & run;
  assign wr = acc & pwrite & is_mapped(paddr);
  assign rd = acc & ~pwrite & is_mapped(paddr);
  assign pslverr = acc & ~is_mapped(paddr);

  always_comb begin
    rdmux = 32'h0000_0000;
    case (paddr)
      `URW_OFF_CTRL1: rdmux[7:0] = ctrl1_q;
      `URW_OFF_CTRL2: rdmux[7:0] = {ctrl2_q[7:2], receiver_sleep_q, 1'b0};
      `URW_OFF_STAT1: rdmux[7:0] = {tx_buffer_empty, tx_complete, rx_buffer_full_q, idle_q,
                                    overrun_q, noise_flag_q, framing_error_flag_q,
                                    parity_error_flag_q};
      `URW_OFF_STAT2: rdmux[7:0] = {line_break_detect_flag_q, rx_edge_flag_q, 2'b00,
                                    s2ctl_q[3:0]};
      `URW_OFF_CTRL3: rdmux[7:0] = {rx_ninth_bit_q, ctrl3_q[6:0]};
      `URW_OFF_DATA: rdmux[7:0] = rx_data_q;
      `URW_OFF_BAUD: rdmux[BAUD_W-1:0] = baud_q;
      default: rdmux = 32'h0000_0000;
    endcase
  end

  // Read data captured in setup so the access phase needs no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && run) begin
      prdata <= rdmux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_q <= `URW_CTRL1_RST;
      ctrl2_q <= `URW_CTRL2_RST;
      s2ctl_q <= `URW_S2CTL_RST;
      ctrl3_q <= `URW_CTRL3_RST;
      baud_q <= `URW_BAUD_RST;
    end else if (wr) begin
      case (paddr)
        `URW_OFF_CTRL1: ctrl1_q <= pwdata[7:0];
        `URW_OFF_CTRL2: ctrl2_q <= {pwdata[7:2], 2'b00};
        `URW_OFF_STAT2: s2ctl_q <= {4'h0, pwdata[3], 1'b0, pwdata[1:0]};
        `URW_OFF_CTRL3: ctrl3_q <= {1'b0, pwdata[6:5], 1'b0, pwdata[3:0]};
        `URW_OFF_BAUD: baud_q <= pwdata[BAUD_W-1:0];
        default: ;
      endcase
    end
  end

  // 16x sample tick; a zero divisor stops the serial side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcnt_q <= '0;
    end else if (run) begin
      bcnt_q <= (bcnt_q + 1'b1 >= baud_q) ? '0 : bcnt_q + 1'b1;
    end
  end
  assign tick16 = run && (baud_q != '0) && (bcnt_q == '0);

  // Receiver source routing
  always_comb begin
    if (loopback_enable && !receiver_source_select) begin
      rx_src = tx_line_q;
    end else if (loopback_enable) begin
      rx_src = single_wire_direction ? 1'b1 : txd_in;
    end else begin
      rx_src = rxd_in;
    end
  end
  assign rxd_pin_used = ~loopback_enable;
  assign txd_out = tx_line_q;
  assign txd_oe = tx_enable &
                  ~(loopback_enable & receiver_source_select & ~single_wire_direction);

  assign nbits = nine_bit ? 4'h9 : 4'h8;
  assign bit_end = tick16 && (rt_q == `URW_RT_LAST);
  assign maj = maj3(smp_q);
  assign noisy = (smp_q != 3'b000) && (smp_q != 3'b111);
  assign frame_bits = nine_bit ? shift_q : {1'b0, shift_q[8:1]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_q <= URW_RX_IDLE;
      rt_q <= 4'h0;
      hist_q <= 3'b000;
      smp_q <= 3'b111;
      bit_idx_q <= 4'h0;
      shift_q <= 9'h000;
      noise_acc_q <= 1'b0;
      stop_ferr_q <= 1'b0;
      stop2_q <= 1'b0;
      am_pend_q <= 1'b0;
      am_wake_q <= 1'b0;
      xfer_q <= 1'b0;
      x_noise_q <= 1'b0;
      x_ferr_q <= 1'b0;
      x_perr_q <= 1'b0;
      x_brk_q <= 1'b0;
      x_ninth_q <= 1'b0;
      x_data_q <= 8'h00;
    end else begin
      // Strobes hold through stop3 so a pending transfer lands after exit
      if (run) begin
        xfer_q <= 1'b0;
        am_wake_q <= 1'b0;
      end
      if (tick16 && !rx_enable) begin
        rx_state_q <= URW_RX_IDLE;
        hist_q <= 3'b000;
      end else if (tick16) begin
        rt_q <= rt_q + 4'h1;
        if (rt_q >= `URW_RT_S1 && rt_q <= `URW_RT_S3) begin
          smp_q <= {rx_src, smp_q[2:1]};
        end
        case (rx_state_q)
          URW_RX_IDLE: begin
            hist_q <= {hist_q[1:0], rx_src};
            if (hist_q == 3'b111 && !rx_src) begin
              rx_state_q <= URW_RX_START;
              rt_q <= 4'h1;
            end
          end
          URW_RX_START: begin
            if (bit_end) begin
              rx_state_q <= maj ? URW_RX_IDLE : URW_RX_DATA;
              noise_acc_q <= noisy;
              bit_idx_q <= 4'h0;
              stop2_q <= 1'b0;
              stop_ferr_q <= 1'b0;
              am_pend_q <= 1'b0;
            end
          end
          URW_RX_DATA: begin
            if (bit_end) begin
              shift_q <= {maj, shift_q[8:1]};
              noise_acc_q <= noise_acc_q | noisy;
              bit_idx_q <= bit_idx_q + 4'h1;
              if (bit_idx_q == nbits - 4'h1) begin
                rx_state_q <= URW_RX_STOP;
                if (maj && wake_addr_mark && receiver_sleep_q) begin
                  am_wake_q <= ~two_stop_bits;
                  am_pend_q <= two_stop_bits;
                end
              end
            end
          end
          URW_RX_STOP: begin
            if (bit_end) begin
              noise_acc_q <= noise_acc_q | noisy;
              if (two_stop_bits && !stop2_q) begin
                // Second one of a two-stop address mark; wakes before the last stop
                stop2_q <= 1'b1;
                stop_ferr_q <= ~maj;
                am_wake_q <= am_pend_q & maj;
              end else begin
                rx_state_q <= URW_RX_IDLE;
                xfer_q <= 1'b1;
                x_data_q <= frame_bits[7:0];
                x_ninth_q <= frame_bits[8];
                x_noise_q <= noise_acc_q | noisy;
                x_ferr_q <= stop_ferr_q | ~maj;
                x_perr_q <= ctrl1_q[`URW_C1_PE] &
                          ((^frame_bits) != ctrl1_q[`URW_C1_PT]);
                x_brk_q <= (frame_bits == 9'h000) & ~maj;
                // Refill edge search after every character but a break so a new start is seen at once
                hist_q <= ((frame_bits != 9'h000) || maj) ? 3'b111 : 3'b000;
              end
            end
          end
          default: rx_state_q <= URW_RX_IDLE;
        endcase
      end
    end
  end

  // Idle detection on whole bit times of idle level
  assign count_ok = (rx_state_q == URW_RX_IDLE) ||
                    (!idle_count_after_stop && rx_state_q != URW_RX_START);
  assign idle_hit = bit_end && maj && count_ok && rx_enable && !idle_done_q &&
                    (idle_cnt_q + 4'h1 == char_bits(nine_bit, two_stop_bits));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt_q <= 4'h0;
      idle_done_q <= 1'b0;
    end else if (tick16 && rx_state_q == URW_RX_IDLE && hist_q == 3'b111 && !rx_src) begin
      idle_cnt_q <= 4'h0;
      idle_done_q <= 1'b0;
    end else if (bit_end) begin
      if (!maj) begin
        idle_cnt_q <= 4'h0;
      end else if (count_ok && !idle_done_q) begin
        idle_cnt_q <= idle_cnt_q + 4'h1;
      end
      if (idle_hit) begin
        idle_done_q <= 1'b1;
      end
    end
  end

  // Sleep bit: software sets or clears it, the line wakes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receiver_sleep_q <= 1'b0;
    end else if (wr && paddr == `URW_OFF_CTRL2) begin
      receiver_sleep_q <= pwdata[`URW_C2_SLEEP];
    end else if ((idle_hit && !wake_addr_mark) || am_wake_q) begin
      receiver_sleep_q <= 1'b0;
    end
  end

  assign blocked = receiver_sleep_q;
  assign idle_set = idle_hit && idle_armed_q &&
                    (!receiver_sleep_q || idle_flag_in_sleep);
  assign rx_edge = run && rx_enable && rx_prev_q && !rx_src;

  // Status read arms the clear; the following data read clears what it showed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_seen_q <= 6'h00;
    end else if (rd && paddr == `URW_OFF_STAT1) begin
      s1_seen_q <= prdata[5:0];
    end else if (rd && paddr == `URW_OFF_DATA) begin
      s1_seen_q <= 6'h00;
    end
  end

  wire data_rd = rd && (paddr == `URW_OFF_DATA);
  wire [5:0] clr = data_rd ? s1_seen_q : 6'h00;
  wire take = xfer_q && !blocked && !framing_error_flag_q;
  wire load = take && !rx_buffer_full_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buffer_full_q <= 1'b0;
      idle_q <= 1'b0;
      overrun_q <= 1'b0;
      noise_flag_q <= 1'b0;
      framing_error_flag_q <= 1'b0;
      parity_error_flag_q <= 1'b0;
      idle_armed_q <= 1'b0;
      rx_data_q <= 8'h00;
      rx_ninth_bit_q <= 1'b0;
    end else if (run) begin
      // Set wins over a clear in the same cycle
      rx_buffer_full_q <= load | (rx_buffer_full_q & ~clr[5]);
      idle_q <= idle_set | (idle_q & ~clr[4]);
      overrun_q <= (take & rx_buffer_full_q) | (overrun_q & ~clr[3]);
      noise_flag_q <= (load & x_noise_q) | (noise_flag_q & ~clr[2]);
      framing_error_flag_q <= (load & x_ferr_q) | (framing_error_flag_q & ~clr[1]);
      parity_error_flag_q <= (load & x_perr_q) | (parity_error_flag_q & ~clr[0]);
      if (load) begin
        idle_armed_q <= 1'b1;
        rx_data_q <= x_data_q;
        rx_ninth_bit_q <= x_ninth_q;
      end else if (clr[4]) begin
        idle_armed_q <= 1'b0;
      end
    end
  end

  // Edge and break flags, cleared by writing one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_prev_q <= 1'b1;
      rx_edge_flag_q <= 1'b0;
      line_break_detect_flag_q <= 1'b0;
    end else begin
      if (run) begin
        rx_prev_q <= rx_src;
      end
      rx_edge_flag_q <= rx_edge |
                        (rx_edge_flag_q & ~(wr && paddr == `URW_OFF_STAT2 &&
                                            pwdata[`URW_S2_EDGE_FLAG]));
      line_break_detect_flag_q <= (xfer_q & x_brk_q & ~blocked) |
                                  (line_break_detect_flag_q &
                                   ~(wr && paddr == `URW_OFF_STAT2 &&
                                     pwdata[`URW_S2_BRK_FLAG]));
    end
  end

  // Transmitter: buffer, then frame shifter on the bit tick
  assign tx_bit_tick = tick16 && (tx_bt_q == `URW_RT_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_bt_q <= 4'h0;
      tx_buf_q <= 8'h00;
      tx_ninth_q <= 1'b0;
      tx_full_q <= 1'b0;
      tx_busy_q <= 1'b0;
      tx_sh_q <= 11'h7FF;
      tx_cnt_q <= 4'h0;
      tx_line_q <= 1'b1;
    end else begin
      if (tick16) begin
        tx_bt_q <= tx_bt_q + 4'h1;
      end
      if (wr && paddr == `URW_OFF_DATA && tx_enable) begin
        tx_buf_q <= pwdata[7:0];
        tx_ninth_q <= tx_ninth_bit;
        tx_full_q <= 1'b1;
      end else if (tx_bit_tick && !tx_busy_q && tx_full_q) begin
        tx_full_q <= 1'b0;
      end
      if (tx_bit_tick) begin
        if (!tx_busy_q && tx_full_q) begin
          tx_busy_q <= 1'b1;
          tx_line_q <= 1'b0;
          tx_sh_q <= {2'b11, nine_bit ? tx_ninth_q : 1'b1, tx_buf_q};
          tx_cnt_q <= char_bits(nine_bit, two_stop_bits) - 4'h1;
        end else if (tx_busy_q && tx_cnt_q == 4'h0) begin
          tx_busy_q <= 1'b0;
          tx_line_q <= 1'b1;
        end else if (tx_busy_q) begin
          tx_line_q <= tx_sh_q[0];
          tx_sh_q <= {1'b1, tx_sh_q[10:1]};
          tx_cnt_q <= tx_cnt_q - 4'h1;
        end
      end
    end
  end

  // Three request lines, each source under its own enable
  assign irq_tx = (ctrl2_q[`URW_C2_TXE_IE] & tx_buffer_empty) |
                  (ctrl2_q[`URW_C2_TXC_IE] & tx_complete);
  assign irq_rx = (ctrl2_q[`URW_C2_RIE] & rx_buffer_full_q) |
                  (ctrl2_q[`URW_C2_ILIE] & idle_q) |
                  (s2ctl_q[`URW_S2_RXEDGIE] & rx_edge_flag_q) |
                  (s2ctl_q[`URW_S2_LBKDIE] & line_break_detect_flag_q);
  assign irq_err = (ctrl3_q[`URW_C3_ORIE] & overrun_q) |
                   (ctrl3_q[`URW_C3_NEIE] & noise_flag_q) |
                   (ctrl3_q[`URW_C3_FEIE] & framing_error_flag_q) |
                   (ctrl3_q[`URW_C3_PEIE] & parity_error_flag_q);

endmodule

// ==== verilog/urw_defines.svh ====
// Register offsets, field positions, reset values and timing counts of the serial block.
// Assumes an 8-bit APB byte address and 32-bit data with registers in the low byte, except the 13-bit divisor in bits 12:0.
`ifndef URW_DEFINES_SVH
`define URW_DEFINES_SVH

`define URW_OFF_CTRL1 8'h00
`define URW_OFF_CTRL2 8'h04
`define URW_OFF_STAT1 8'h08
`define URW_OFF_STAT2 8'h0C
`define URW_OFF_CTRL3 8'h10
`define URW_OFF_DATA 8'h14
`define URW_OFF_BAUD 8'h18

// Control 1
`define URW_C1_LOOP 0
`define URW_C1_RX_SRC 1
`define URW_C1_NINE 2
`define URW_C1_WAKE 3
`define URW_C1_IDLE_AFTER_STOP 4
`define URW_C1_PE 5
`define URW_C1_PT 6
`define URW_C1_TWO_STOP 7
// Control 2
`define URW_C2_SLEEP 1
`define URW_C2_RE 2
`define URW_C2_TE 3
`define URW_C2_ILIE 4
`define URW_C2_RIE 5
`define URW_C2_TXC_IE 6
`define URW_C2_TXE_IE 7
// Status 2 (control part and flags)
`define URW_S2_RXEDGIE 0
`define URW_S2_LBKDIE 1
`define URW_S2_IDLE_SLEEP 3
`define URW_S2_EDGE_FLAG 6
`define URW_S2_BRK_FLAG 7
// Control 3
`define URW_C3_PEIE 0
`define URW_C3_FEIE 1
`define URW_C3_NEIE 2
`define URW_C3_ORIE 3
`define URW_C3_SW_DIR 5
`define URW_C3_TX9 6

// Reset values
`define URW_CTRL1_RST 8'h00
`define URW_CTRL2_RST 8'h00
`define URW_S2CTL_RST 8'h00
`define URW_CTRL3_RST 8'h00
`define URW_BAUD_RST 13'h0004

// Timing: 16 samples per bit, samples taken at RT8..RT10, base frame of 10 bits
`define URW_RT_LAST 4'hF
`define URW_RT_S1 4'h7
`define URW_RT_S3 4'h9
`define URW_CHAR_BASE 4'hA

`endif

// ==== verilog/urw_pkg.sv ====
// Types shared by the serial wakeup and flag block.
// Assumes nothing beyond a SystemVerilog compiler.
package urw_pkg;

  typedef enum logic [3:0] {
    URW_RX_IDLE = 4'b0001,
    URW_RX_START = 4'b0010,
    URW_RX_DATA = 4'b0100,
    URW_RX_STOP = 4'b1000
  } urw_rx_state_t;

endpackage

// ==== testbench/urw_top_asserts.sv ====
// Port-level checks of the serial wakeup and flag block, bound to urw_top.
// Assumes control registers change only through complete APB write cycles.
`timescale 1ns/1ps
module urw_top_asserts (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Pins
  input wire logic txd_out,
  input wire logic txd_oe,
  input wire logic rxd_pin_used,
  input wire logic stop3_mode,
  // Interrupts
  input wire logic irq_tx,
  input wire logic irq_rx,
  input wire logic irq_err
);
  logic wr_s, rd_s1;
  logic [7:0] c1_q, c2_q, c3_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign wr_s = psel && penable && pready && pwrite;
  assign rd_s1 = psel && penable && pready && !pwrite && paddr == 8'h08;
  // Shadow of written control bits; the hardware-cleared sleep bit is never used
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c1_q <= 8'h00;
      c2_q <= 8'h00;
      c3_q <= 8'h00;
    end else if (wr_s) begin
      c1_q <= paddr == 8'h00 ? pwdata[7:0] : c1_q;
      c2_q <= paddr == 8'h04 ? pwdata[7:0] : c2_q;
      c3_q <= paddr == 8'h10 ? pwdata[7:0] : c3_q;
    end
  end
  pin_release_a: assert property (rxd_pin_used == !c1_q[0])
    else $error("receive pin use differs from loop setting");
  drive_dir_a: assert property (txd_oe == (c2_q[3] && !(c1_q[0] && c1_q[1] && !c3_q[5])))
    else $error("transmit pin drive differs from direction setting");
  tx_mask_a: assert property (!c2_q[7] && !c2_q[6] |-> !irq_tx)
    else $error("transmit request while both sources masked");
  err_mask_a: assert property (c3_q[3:0] == 4'h0 |-> !irq_err)
    else $error("error request while all sources masked");
  empty_irq_a: assert property (rd_s1 && prdata[7] && c2_q[7] |-> irq_tx)
    else $error("no transmit request with buffer empty");
  full_irq_a: assert property (rd_s1 && prdata[5] && c2_q[5] |-> irq_rx)
    else $error("no receive request with buffer full");
  overrun_irq_a: assert property (rd_s1 && prdata[3] && c3_q[3] |-> irq_err)
    else $error("no error request on overrun");
  stop_stall_a: assert property (stop3_mode |-> !pready)
    else $error("bus answered during stop");
  stop_freeze_a: assert property (stop3_mode [*2] |-> $stable(txd_out) && $stable(irq_rx))
    else $error("outputs moved during stop");
  cover property (rd_s1 && prdata[5]);
  cover property (rd_s1 && prdata[3]);
  cover property (stop3_mode [*2]);
endmodule

bind urw_top urw_top_asserts u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .txd_out, .txd_oe, .rxd_pin_used, .stop3_mode, .irq_tx, .irq_rx, .irq_err
);

// ==== testbench/urw_serial_node.sv ====
// Remote serial node: sends framed characters lsb first on one line.
// Assumes the bench programs the divisor that gives BIT_CYC clocks per bit.
`timescale 1ns/1ps
module urw_serial_node #(
  parameter int BIT_CYC = 16
) (
  // Clock
  input wire logic clk,
  // Line
  output logic line
);
  // Idle mark level; line pulled high between frames
  initial line = 1'h1;
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      line <= bits[i];
      repeat (BIT_CYC) @(posedge clk);
    end
    line <= 1'h1;
    // One mark cycle so a following frame never assigns the line in the same step
    @(posedge clk);
  endtask
endmodule

// ==== testbench/uart_rx_wakeup_flags_modes_tb.sv ====
// Self-checking bench of the serial wakeup and flag block over APB and one serial line.
// Assumes the remote node model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module uart_rx_wakeup_flags_modes_tb;
  localparam logic [7:0] C1 = 8'h00, C2 = 8'h04, S1 = 8'h08, S2 = 8'h0C, C3 = 8'h10, DT = 8'h14;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic stop3_mode = 1'h0, rx_open = 1'h1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic ln, rxd_w, pready, pslverr, txd_out, txd_oe, rxd_pin_used, irq_tx, irq_rx, irq_err, err;
  logic [31:0] prdata, q;
  int failures = 0;
  int compares = 0;
  // Pin held low in loop modes so any use of it shows
  assign rxd_w = ln & rx_open;
  always #50 pclk = ~pclk;
  urw_serial_node #(.BIT_CYC(16)) node (.clk(pclk), .line(ln));
  urw_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd_in(rxd_w), .txd_in(ln), .txd_out(txd_out), .txd_oe(txd_oe),
    .rxd_pin_used(rxd_pin_used), .stop3_mode(stop3_mode), .irq_tx(irq_tx),
    .irq_rx(irq_rx), .irq_err(irq_err));
  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // Only the watchdog ends a stalled access
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk($sformatf("reg %h", a), e, q);
  endtask
  // Poll status until receive full, bounded
  task automatic wfull();
    int n;
    n = 0;
    do begin
      apb(1'h0, S1, 32'h0);
      n++;
    end while (q[5] !== 1'h1 && n < 100);
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rd(S1, 32'hC0);
    rd(8'h1C, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    wr(C2, 32'hC0);
    chk("irq_tx", 32'h1, {31'h0, irq_tx});
    rd(S1, 32'hC0);
    wr(8'h18, 32'h1);
    wr(C2, 32'h24);
    wr(C3, 32'h08);
    node.send({3'h7, 8'h5A, 1'h0}, 10);
    wfull();
    chk("irq_rx", 32'h1, {31'h0, irq_rx});
    rd(S1, 32'hE0);
    rd(DT, 32'h5A);
    rd(S1, 32'hC0);
    node.send({3'h7, 8'hA1, 1'h0}, 10);
    node.send({3'h7, 8'hA2, 1'h0}, 10);
    repeat (32) @(posedge pclk);
    chk("irq_err", 32'h1, {31'h0, irq_err});
    rd(S1, 32'hE8);
    rd(DT, 32'hA1);
    rd(S1, 32'hC0);
    repeat (200) @(posedge pclk);
    rd(S1, 32'hD0);
    rd(DT, 32'hA1);
    rd(S1, 32'hC0);
    repeat (200) @(posedge pclk);
    rd(S1, 32'hC0);
    node.send({3'h6, 8'h5A, 1'h0}, 10);
    wfull();
    rd(S1, 32'hE2);
    rd(DT, 32'h5A);
    rd(S2, 32'h40);
    wr(S2, 32'h40);
    rd(S2, 32'h00);
    wr(C1, 32'h08);
    wr(C2, 32'h06);
    node.send({3'h7, 8'h33, 1'h0}, 10);
    repeat (32) @(posedge pclk);
    rd(S1, 32'hC0);
    rd(C2, 32'h06);
    node.send({3'h7, 8'hB3, 1'h0}, 10);
    wfull();
    rd(C2, 32'h04);
    rd(S1, 32'hE0);
    rd(DT, 32'hB3);
    wr(C1, 32'h00);
    wr(C2, 32'h06);
    node.send({3'h7, 8'h00, 1'h0}, 10);
    rd(C2, 32'h06);
    repeat (176) @(posedge pclk);
    rd(C2, 32'h04);
    rd(S1, 32'hC0);
    wr(C1, 32'h01);
    rx_open <= 1'h0;
    wr(C2, 32'h0C);
    wr(DT, 32'hA5);
    wfull();
    rd(S1, 32'hE0);
    rd(DT, 32'hA5);
    wr(C1, 32'h05);
    wr(C3, 32'h40);
    wr(DT, 32'h3C);
    wfull();
    rd(C3, 32'hC0);
    rd(DT, 32'h3C);
    wr(C1, 32'h03);
    wr(C3, 32'h20);
    wr(DT, 32'h55);
    repeat (240) @(posedge pclk);
    rd(S1, 32'hD0);
    wr(C3, 32'h00);
    node.send({3'h7, 8'h66, 1'h0}, 10);
    wfull();
    rd(DT, 32'h66);
    node.send({3'h7, 8'h11, 1'h0}, 10);
    wfull();
    wr(S2, 32'h08);
    wr(C2, 32'h06);
    repeat (176) @(posedge pclk);
    rd(S1, 32'hF0);
    rd(C2, 32'h04);
    stop3_mode <= 1'h1;
    repeat (6) @(posedge pclk);
    stop3_mode <= 1'h0;
    @(posedge pclk);
    rd(C1, 32'h03);
    summarize();
  end
endmodule
